/* File: rtl/ssps_core.sv */
// Synchronous serial port with master and slave modes and select management.
`timescale 1ns/100ps
module ssps_core
  import ssps_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // CPU access strobes.
  input wire logic ctrl_wr_in,
  input wire logic stat_wr_in,
  input wire logic stat_rd_in,
  input wire logic data_wr_in,
  input wire logic data_rd_in,
  input wire logic [7:0] wdata_in,
  // CPU read data.
  output logic [7:0] serial_control_reg_out,
  output logic [7:0] serial_ctrl_status_reg_out,
  output logic [7:0] serial_data_reg_out,
  output logic irq_out,
  // Serial pins.
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic sel_n_in
);
  logic [7:0] ctrl_reg;
  logic soft_man_reg, soft_lvl_reg;
  logic done_reg, write_collision_flag_reg, master_fault_flag_reg, ovr_reg;
  logic done_armed_reg, master_fault_flag_armed_reg, wr_block_reg;
  logic [7:0] shift_reg, rxbuf_reg;
  logic [2:0] cnt_reg;
  logic [6:0] div_reg;
  logic sck_reg, sample_reg;
  ssps_state_t state_reg;
  logic [2:0] pins_sync;
  logic sck_s, sel_s, mosi_s, sck_d_reg, sel_d_reg;
  logic sel_int, master, enabled, cpha, cpol, busy;
  logic lead_edge, trail_edge, sample_edge, shift_edge, byte_end, first_lead;
  logic data_wr_ok, slave_sel_rise, ser_in;
  logic [6:0] half;

  // External clock and select are resynchronised before any use.
  ssps_sync #(.WIDTH(3)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in({mosi_in, sck_in, sel_n_in}),
    .sync_out(pins_sync)
  );
  assign mosi_s = pins_sync[2];
  assign sck_s = pins_sync[1];
  assign sel_s = pins_sync[0];

  assign master = ctrl_reg[SSPS_CR_MASTER_SELECT];
  assign enabled = ctrl_reg[SSPS_CR_SPE];
  assign cpha = ctrl_reg[SSPS_CR_CPHA];
  assign cpol = ctrl_reg[SSPS_CR_CPOL];
  assign sel_int = soft_man_reg ? soft_lvl_reg : sel_s;
  assign busy = state_reg != SSPS_IDLE;

  function automatic logic [6:0] half_of(input logic [2:0] spr);
    unique case (spr)
      3'h0: half_of = SSPS_HALF_0;
      3'h1: half_of = SSPS_HALF_1;
      3'h2: half_of = SSPS_HALF_2;
      3'h3: half_of = SSPS_HALF_3;
      3'h4: half_of = SSPS_HALF_4;
      3'h5: half_of = SSPS_HALF_5;
      default: half_of = SSPS_HALF_2;
    endcase
  endfunction
  // Six rates; the fastest toggles every two CPU cycles, i.e. CPU/4.
  assign half = half_of({ctrl_reg[SSPS_CR_SPR2], ctrl_reg[SSPS_CR_SPR1], ctrl_reg[SSPS_CR_SPR0]});

  // Edge detection on the serial clock: generated in master, sensed in slave.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_int;
    end
  end
  assign slave_sel_rise = sel_int && !sel_d_reg;

  logic m_tick;
  assign m_tick = master && busy && (div_reg == half - 7'h01);
  // Slave edges are valid only while the internal select is low.
  logic s_edge;
  assign s_edge = !master && enabled && !sel_int && (sck_s != sck_d_reg);
  assign lead_edge = (master ? m_tick && state_reg == SSPS_LEAD : s_edge && (sck_s != cpol));
  assign trail_edge = (master ? m_tick && state_reg == SSPS_TRAIL : s_edge && (sck_s == cpol));
  // Phase zero samples on the first edge, phase one on the second.
  assign sample_edge = cpha ? trail_edge : lead_edge;
  assign shift_edge = cpha ? lead_edge : trail_edge;
  assign byte_end = trail_edge && cnt_reg == SSPS_CNT_LAST;
  // The first leading edge of a byte: an idle slave, or a master still on bit zero.
  assign first_lead = cnt_reg == 3'h0 && state_reg != SSPS_TRAIL;
  // Master input is taken raw, since it moves only after our own clock edges.
  assign ser_in = master ? miso_in : mosi_s;

  // Writes are refused while shifting or while done awaits a status read or write.
  assign data_wr_ok = data_wr_in && !busy && !wr_block_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= 7'h00;
    end else if (!master || !busy || m_tick) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  // Transfer sequencing; only a master starts a byte on its own.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= SSPS_IDLE;
      cnt_reg <= 3'h0;
    end else if (!enabled) begin
      state_reg <= SSPS_IDLE;
      cnt_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        SSPS_IDLE: begin
          if (master && data_wr_ok) begin
            state_reg <= SSPS_LEAD;
          end else if (!master && !sel_int && lead_edge) begin
            state_reg <= SSPS_TRAIL;
          end
          cnt_reg <= 3'h0;
        end
        SSPS_LEAD: begin
          if (lead_edge) begin
            state_reg <= SSPS_TRAIL;
          end
        end
        SSPS_TRAIL: begin
          if (byte_end) begin
            state_reg <= SSPS_IDLE;
          end else if (trail_edge) begin
            state_reg <= SSPS_LEAD;
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        default: state_reg <= SSPS_IDLE;
      endcase
    end
  end

  // Shift register, MSB first in both directions.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_reg <= SSPS_BYTE_RST;
      sample_reg <= 1'b0;
    end else if (data_wr_ok) begin
      shift_reg <= wdata_in;
    end else begin
      if (sample_edge) begin
        sample_reg <= ser_in;
      end
      // Phase one already shows the MSB, so its first leading edge moves nothing.
      if (shift_edge && !(cpha && first_lead)) begin
        shift_reg <= {shift_reg[SSPS_BITS-2:0], sample_reg};
      end
    end
  end

  logic [7:0] rx_byte;
  assign rx_byte = {shift_reg[SSPS_BITS-2:0], cpha ? ser_in : sample_reg};

  // Master clock generation: idles at the polarity level.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_reg <= 1'b0;
    end else if (!master || !busy) begin
      sck_reg <= cpol;
    end else if (m_tick) begin
      sck_reg <= !sck_reg;
    end
  end
  assign sck_out = sck_reg;
  assign sck_oe_out = enabled && master;
  assign mosi_out = shift_reg[SSPS_BITS-1];
  assign miso_out = shift_reg[SSPS_BITS-1];
  // Slave drives MISO only while selected, so the line can be shared.
  assign mosi_oe_out = enabled && master;
  assign miso_oe_out = enabled && !master && !sel_int;

  // Receive buffer keeps the first unread byte on overrun.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxbuf_reg <= SSPS_BYTE_RST;
    end else if (byte_end && !done_reg) begin
      rxbuf_reg <= rx_byte;
    end
  end

  // Done flag and its two-step clear; a new completion wins over the clear.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_reg <= 1'b0;
      done_armed_reg <= 1'b0;
      wr_block_reg <= 1'b0;
    end else begin
      if (byte_end) begin
        done_reg <= 1'b1;
        wr_block_reg <= 1'b1;
        done_armed_reg <= 1'b0;
      end else begin
        if (stat_rd_in || stat_wr_in) begin
          wr_block_reg <= 1'b0;
          done_armed_reg <= done_reg;
        end
        if (done_armed_reg && (data_rd_in || data_wr_in)) begin
          done_reg <= 1'b0;
          done_armed_reg <= 1'b0;
        end
      end
    end
  end

  // Overrun set on completion while done still set; cleared by status read.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovr_reg <= 1'b0;
    end else if (byte_end && done_reg) begin
      ovr_reg <= 1'b1;
    end else if (stat_rd_in) begin
      ovr_reg <= 1'b0;
    end
  end

  // Collision: write during transfer, or phase-zero slave write still selected.
  logic write_collision_flag_set, write_collision_flag_armed_reg, sel_seen_high_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_seen_high_reg <= 1'b1;
    end else if (byte_end) begin
      sel_seen_high_reg <= 1'b0;
    end else if (slave_sel_rise) begin
      sel_seen_high_reg <= 1'b1;
    end
  end
  assign write_collision_flag_set = data_wr_in && !wr_block_reg && (busy ||
                    (!master && !cpha && !sel_int && !sel_seen_high_reg));
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_collision_flag_reg <= 1'b0;
      write_collision_flag_armed_reg <= 1'b0;
    end else if (write_collision_flag_set) begin
      write_collision_flag_reg <= 1'b1;
    end else begin
      if (stat_rd_in) begin
        write_collision_flag_armed_reg <= write_collision_flag_reg;
      end else if (write_collision_flag_armed_reg && data_rd_in) begin
        write_collision_flag_reg <= 1'b0;
        write_collision_flag_armed_reg <= 1'b0;
      end
    end
  end

  // Master fault: select low while master drops enable and master select.
  logic fault;
  assign fault = master && enabled && !sel_int;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      master_fault_flag_reg <= 1'b0;
      master_fault_flag_armed_reg <= 1'b0;
    end else if (fault) begin
      master_fault_flag_reg <= 1'b1;
    end else if (stat_rd_in && master_fault_flag_reg) begin
      master_fault_flag_armed_reg <= 1'b1;
    end else if (master_fault_flag_armed_reg && ctrl_wr_in) begin
      master_fault_flag_reg <= 1'b0;
      master_fault_flag_armed_reg <= 1'b0;
    end
  end

  // Control register; enable and master cannot be set while a fault stands.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= 8'h00;
    end else if (fault) begin
      ctrl_reg[SSPS_CR_SPE] <= 1'b0;
      ctrl_reg[SSPS_CR_MASTER_SELECT] <= 1'b0;
    end else if (ctrl_wr_in) begin
      ctrl_reg <= wdata_in;
      if (master_fault_flag_reg && !master_fault_flag_armed_reg) begin
        ctrl_reg[SSPS_CR_SPE] <= 1'b0;
        ctrl_reg[SSPS_CR_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      soft_man_reg <= 1'b0;
      soft_lvl_reg <= 1'b0;
    end else if (stat_wr_in) begin
      soft_man_reg <= wdata_in[SSPS_SR_SOFTMAN];
      soft_lvl_reg <= wdata_in[SSPS_SR_SOFTLVL];
    end
  end

  assign serial_control_reg_out = ctrl_reg;
  always_comb begin
    serial_ctrl_status_reg_out = 8'h00;
    serial_ctrl_status_reg_out[SSPS_SR_DONE] = done_reg;
    serial_ctrl_status_reg_out[SSPS_SR_WRITE_COLLISION_FLAG] = write_collision_flag_reg;
    serial_ctrl_status_reg_out[SSPS_SR_OVR] = ovr_reg;
    serial_ctrl_status_reg_out[SSPS_SR_MASTER_FAULT_FLAG] = master_fault_flag_reg;
    serial_ctrl_status_reg_out[SSPS_SR_SOFTMAN] = soft_man_reg;
    serial_ctrl_status_reg_out[SSPS_SR_SOFTLVL] = soft_lvl_reg;
  end
  assign serial_data_reg_out = rxbuf_reg;
  assign irq_out = ctrl_reg[SSPS_CR_IE] && (done_reg || master_fault_flag_reg || ovr_reg);

  AST_DONE_ON_END: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    byte_end |=> done_reg)
    else $error("done flag not set after byte end");
  AST_FAULT_DROPS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fault |=> master_fault_flag_reg && !ctrl_reg[SSPS_CR_SPE] && !ctrl_reg[SSPS_CR_MASTER_SELECT])
    else $error("fault did not clear enable and master");
  AST_WR_BLOCK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (done_reg && wr_block_reg && data_wr_in && !byte_end) |=> $stable(shift_reg))
    else $error("data write taken while done pending");
  AST_OVR_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (byte_end && done_reg) |=> ovr_reg && $stable(rxbuf_reg))
    else $error("overrun not flagged or buffer overwritten");
  AST_OVR_CLR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (stat_rd_in && !(byte_end && done_reg)) |=> !ovr_reg)
    else $error("overrun not cleared by status read");
  AST_SOFT_SEL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    soft_man_reg |-> sel_int == soft_lvl_reg)
    else $error("internal select not from level bit");
  AST_MISO_OE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    miso_oe_out |-> !master && !sel_int && !mosi_oe_out && !sck_oe_out)
    else $error("slave output enabled wrongly");
  AST_MSB_OUT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    data_wr_ok |=> mosi_out == $past(wdata_in[SSPS_BITS-1]))
    else $error("first bit out is not the msb");
  AST_WRITE_COLLISION_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (data_wr_in && busy && !wr_block_reg) |=> write_collision_flag_reg)
    else $error("write collision not flagged");
  AST_FAST_CLK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (master && busy && $changed(sck_reg)) |=> !$changed(sck_reg))
    else $error("master clock faster than cpu over four");
endmodule

/* File: common/ssps_pkg.sv */
// Constants and types shared by the synchronous serial port design.
package ssps_pkg;
  localparam int SSPS_BITS = 8;
  localparam logic [2:0] SSPS_CNT_LAST = 3'h7;
  localparam logic [7:0] SSPS_BYTE_RST = 8'h00;
  // Control register fields.
  localparam int SSPS_CR_SPR0 = 0;
  localparam int SSPS_CR_SPR1 = 1;
  localparam int SSPS_CR_CPHA = 2;
  localparam int SSPS_CR_CPOL = 3;
  localparam int SSPS_CR_MASTER_SELECT = 4;
  localparam int SSPS_CR_SPR2 = 5;
  localparam int SSPS_CR_SPE = 6;
  localparam int SSPS_CR_IE = 7;
  // Control/status register fields.
  localparam int SSPS_SR_SOFTLVL = 0;
  localparam int SSPS_SR_SOFTMAN = 1;
  localparam int SSPS_SR_MASTER_FAULT_FLAG = 4;
  localparam int SSPS_SR_OVR = 5;
  localparam int SSPS_SR_WRITE_COLLISION_FLAG = 6;
  localparam int SSPS_SR_DONE = 7;
  // Half-period of the master serial clock in CPU cycles, indexed by SPR.
  localparam logic [6:0] SSPS_HALF_0 = 7'h08;
  localparam logic [6:0] SSPS_HALF_1 = 7'h10;
  localparam logic [6:0] SSPS_HALF_2 = 7'h40;
  localparam logic [6:0] SSPS_HALF_3 = 7'h02;
  localparam logic [6:0] SSPS_HALF_4 = 7'h04;
  localparam logic [6:0] SSPS_HALF_5 = 7'h20;
  typedef enum logic [1:0] {
    SSPS_IDLE = 2'b00,
    SSPS_LEAD = 2'b01,
    SSPS_TRAIL = 2'b10
  } ssps_state_t;
endpackage

/* File: rtl/ssps_sync.sv */
// Two-flop synchroniser for external pin levels.
`timescale 1ns/100ps
module ssps_sync
  import ssps_pkg::*;
#(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* File: verification/ssps_slave_model.sv */
// External serial slave that answers a master-mode port, all four clock modes.
`timescale 1ns/100ps
module ssps_slave_model (
  // Serial pins.
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic sel_n_in,
  output logic miso_out,
  // Mode and data.
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic [7:0] tx_in,
  output logic [7:0] rx_out
);
  logic [7:0] sh_reg = 8'h00;
  logic d_reg = 1'b0;
  initial rx_out = 8'h00;
  // A released line shows the inverse of the last bit so a stale value never matches.
  assign miso_out = sel_n_in ? ~d_reg : d_reg;
  always @(negedge sel_n_in) begin
    d_reg = tx_in[7];
    sh_reg = cpha_in ? tx_in : {tx_in[6:0], 1'b0};
  end
  always @(sck_in) begin
    if (!sel_n_in) begin
      if ((sck_in ^ cpol_in) != cpha_in) begin
        rx_out = {rx_out[6:0], mosi_in};
      end else begin
        d_reg = sh_reg[7];
        sh_reg = {sh_reg[6:0], 1'b0};
      end
    end
  end
endmodule

/* File: verification/ssps_core_tb.sv */
// Self-checking bench for the serial port in master and slave modes.
`timescale 1ns/100ps
module ssps_core_tb;
  import ssps_pkg::*;
  localparam int H = 8;
  localparam logic [7:0] SM_HI = 8'h03;
  localparam logic [7:0] SM_LO = 8'h02;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] st = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic t_sck = 1'b0;
  logic t_mosi = 1'b0;
  logic t_sel_n = 1'b1;
  logic m_sel_n = 1'b1;
  logic m_cpol = 1'b0;
  logic m_cpha = 1'b0;
  logic [7:0] m_tx = 8'h00;
  logic [7:0] m_rx;
  logic [7:0] cr_o, sr_o, dr_o, r;
  logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, m_miso;
  logic [6:0] half_tab [6] = '{SSPS_HALF_0, SSPS_HALF_1, SSPS_HALF_2, SSPS_HALF_3, SSPS_HALF_4, SSPS_HALF_5};
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_edge = 0;
  ssps_core uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ctrl_wr_in(st[0]), .stat_wr_in(st[1]),
    .stat_rd_in(st[2]), .data_wr_in(st[3]), .data_rd_in(st[4]), .wdata_in(wdata),
    .serial_control_reg_out(cr_o), .serial_ctrl_status_reg_out(sr_o), .serial_data_reg_out(dr_o),
    .irq_out(irq), .sck_in(t_sck), .sck_out(sck_o), .sck_oe_out(sck_oe), .mosi_in(t_mosi),
    .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_in(m_miso), .miso_out(miso_o),
    .miso_oe_out(miso_oe), .sel_n_in(t_sel_n));
  ssps_slave_model slave (.sck_in(sck_oe ? sck_o : m_cpol), .mosi_in(mosi_o), .sel_n_in(m_sel_n),
    .miso_out(m_miso), .cpol_in(m_cpol), .cpha_in(m_cpha), .tx_in(m_tx), .rx_out(m_rx));
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(sck_o) n_edge++;
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("[FAIL] timeout expected end seen hang");
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cpu(input int k, input logic [7:0] d);
    @(posedge clk_sys_in);
    wdata <= d;
    st[k] <= 1'b1;
    @(posedge clk_sys_in);
    st <= 5'h00;
    #1;
  endtask
  function automatic logic [7:0] cr(input logic [2:0] spr, input logic cpol, cpha, master_select);
    cr = 8'h00;
    cr[SSPS_CR_SPR0] = spr[0];
    cr[SSPS_CR_SPR1] = spr[1];
    cr[SSPS_CR_SPR2] = spr[2];
    cr[SSPS_CR_CPOL] = cpol;
    cr[SSPS_CR_CPHA] = cpha;
    cr[SSPS_CR_MASTER_SELECT] = master_select;
    cr[SSPS_CR_SPE] = 1'b1;
    cr[SSPS_CR_IE] = 1'b1;
  endfunction
  task automatic wait_done();
    int n = 0;
    while (sr_o[SSPS_SR_DONE] !== 1'b1 && n < 3000) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask
  // Master transfer with the slave model; optional write while busy and write while done.
  task automatic mx(input logic [2:0] spr, input logic cpol, cpha, input logic [7:0] a, b, input logic wc);
    int t0;
    int el;
    logic [7:0] es;
    m_cpol = cpol;
    m_cpha = cpha;
    m_tx = b;
    cpu(1, SM_HI);
    cpu(0, cr(spr, cpol, cpha, 1'b1));
    // Let the idle clock settle to the new polarity before selecting the slave.
    repeat (2) @(posedge clk_sys_in);
    m_sel_n <= 1'b0;
    n_edge = 0;
    cpu(3, a);
    t0 = cyc;
    if (wc) cpu(3, 8'h5a);
    wait_done();
    el = cyc - t0;
    chk("rate", 8'h01, {7'h00, el >= 16 * int'(half_tab[spr]) - 2 && el <= 16 * int'(half_tab[spr]) + 3});
    chk("sck edges", 8'h10, 8'(n_edge));
    chk("slave rx", a, m_rx);
    es = SM_HI | (8'h01 << SSPS_SR_DONE) | (wc ? (8'h01 << SSPS_SR_WRITE_COLLISION_FLAG) : 8'h00);
    chk("status done", es, sr_o);
    chk("irq", 8'h01, {7'h00, irq});
    if (wc) begin
      n_edge = 0;
      cpu(3, 8'hff);
      repeat (8) @(posedge clk_sys_in);
      #1;
      chk("blocked write", 8'h00, 8'(n_edge));
      chk("status held", es, sr_o);
    end
    cpu(2, 8'h00);
    cpu(4, 8'h00);
    chk("master rx", b, dr_o);
    chk("status clear", SM_HI, sr_o);
    @(posedge clk_sys_in) m_sel_n <= 1'b1;
  endtask
  // Bench acts as external master at a slow serial clock, polarity low.
  task automatic xfer(input logic [7:0] tx, input logic cpha, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_sys_in);
      if (!cpha) t_mosi <= tx[i];
      repeat (H) @(posedge clk_sys_in);
      if (!cpha) rx[i] = miso_o;
      t_sck <= 1'b1;
      if (cpha) t_mosi <= tx[i];
      repeat (H) @(posedge clk_sys_in);
      if (cpha) rx[i] = miso_o;
      t_sck <= 1'b0;
    end
    repeat (H) @(posedge clk_sys_in);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    chk("ctrl rst", 8'h00, cr_o);
    chk("status rst", 8'h00, sr_o);
    chk("data rst", 8'h00, dr_o);
    chk("oe rst", 8'h00, {4'h0, sck_oe, mosi_oe, miso_oe, irq});
    $display("test reset done");
    @(posedge clk_sys_in) t_sel_n <= 1'b0;
    for (int m = 0; m < 4; m++) mx(3'h3, m[1], m[0], 8'h81 + 8'(m), 8'h3c ^ 8'(m), m == 0);
    for (int s = 0; s < 6; s++) mx(3'(s), 1'b0, 1'b0, 8'hc9, 8'h4e, 1'b0);
    $display("test master done");
    cpu(1, 8'h00);
    cpu(0, cr(3'h0, 1'b0, 1'b0, 1'b1));
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk("fault", 8'h10, sr_o);
    chk("fault ctrl", 8'h00, cr_o & ((8'h01 << SSPS_CR_SPE) | (8'h01 << SSPS_CR_MASTER_SELECT)));
    chk("fault irq", 8'h01, {7'h00, irq});
    @(posedge clk_sys_in) t_sel_n <= 1'b1;
    cpu(2, 8'h00);
    cpu(0, 8'h00);
    chk("fault clear", 8'h00, sr_o);
    $display("test fault done");
    cpu(1, SM_LO);
    cpu(0, cr(3'h0, 1'b0, 1'b1, 1'b0));
    cpu(3, 8'hc3);
    xfer(8'h96, 1'b1, r);
    chk("miso", 8'hc3, r);
    chk("slave rx", 8'h96, dr_o);
    xfer(8'h3c, 1'b1, r);
    chk("overrun", SM_LO | 8'h80 | 8'h20, sr_o);
    chk("first kept", 8'h96, dr_o);
    cpu(2, 8'h00);
    chk("ovr clear", SM_LO | 8'h80, sr_o);
    cpu(4, 8'h00);
    chk("done clear", SM_LO, sr_o);
    $display("test slave done");
    cpu(1, 8'h00);
    cpu(0, cr(3'h0, 1'b0, 1'b0, 1'b0));
    cpu(3, 8'ha5);
    @(posedge clk_sys_in) t_sel_n <= 1'b0;
    xfer(8'h5a, 1'b0, r);
    chk("miso phase0", 8'ha5, r);
    chk("rx phase0", 8'h5a, dr_o);
    cpu(2, 8'h00);
    cpu(4, 8'h00);
    cpu(3, 8'h11);
    chk("write_collision_flag", 8'h40, sr_o);
    cpu(2, 8'h00);
    cpu(4, 8'h00);
    chk("write_collision_flag clear", 8'h00, sr_o);
    @(posedge clk_sys_in) t_sel_n <= 1'b1;
    $display("test collision done");
    conclude();
  end
endmodule
